// >>> hdl/lhp_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// shared constants of the lcd host port
// ----------------------------------------------------------------
package lhp_pkg;
   // positions inside the synchronised pin vector
   localparam int PIN_W = 15;
   localparam int P_D0 = 0;            // data pins 7..0 start here
   localparam int P_SCL = 6;           // serial clock shares data pin 6
   localparam int P_SI = 7;            // serial data shares data pin 7
   localparam int P_WR = 8;            // write strobe, or direction in enable style
   localparam int P_RD = 9;            // read strobe, or enable strobe
   localparam int P_A0 = 10;           // data_command_select
   localparam int P_CS2 = 11;          // chip_select_high_active
   localparam int P_CSN = 12;          // chip_select_low_active
   localparam int P_STY = 13;          // bus_style_strap
   localparam int P_PS = 14;           // parallel/serial strap
   // display ram geometry
   localparam int NUM_PAGES = 9;
   localparam int NUM_COLS = 132;
   localparam logic [3:0] IND_PAGE = 4'h8;
   localparam logic [7:0] COL_LAST = 8'h83;
   localparam logic [6:0] NUM_LINES = 7'h41;
   localparam logic [2:0] SER_LAST = 3'h7;
   localparam logic [7:0] FULL_MASK = 8'hff;
   localparam logic [7:0] IND_MASK = 8'h01;
   // axi4-lite register map, byte addresses
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_PAGE = 8'h00;
   localparam logic [7:0] REG_COLUMN = 8'h04;
   localparam logic [7:0] REG_START = 8'h08;
   localparam logic [7:0] REG_SEGDIR = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [7:0] REG_CMD = 8'h14;
   localparam logic [7:0] REG_LINK = 8'h18;
   localparam int CMD_VALID_BIT = 8;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : lhp_pkg
`default_nettype wire

// >>> hdl/lhp_host_port.sv
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`default_nettype none
module lhp_host_port
   import lhp_pkg::*;
(
   input wire logic clk_i,
   input wire logic resetn_i,
   // host pins, all asynchronous to clk_i
   input wire logic parallel_strap_i,
   input wire logic bus_style_strap_i,
   input wire logic chip_select_low_active_n_i,
   input wire logic chip_select_high_active_i,
   input wire logic data_command_select_i,
   input wire logic rd_strobe_i,
   input wire logic wr_strobe_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   // refresh side, same clock domain as clk_i
   input wire logic [5:0] scan_row_i,
   input wire logic [7:0] scan_col_i,
   output logic seg_dot_o,
   output logic indicator_row_output_o,
   // axi4-lite slave
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PIN_W-1:0] sy1;          // first synchroniser stage
      logic [PIN_W-1:0] sy2;          // second stage, first one logic reads
      logic [PIN_W-1:0] prv;          // previous sy2, for edge finding
      logic [2:0] fill;               // pins settled since reset, one bit per edge
      logic [NUM_PAGES-1:0][NUM_COLS-1:0][7:0] ram;
      logic [3:0] page;               // page address
      logic [7:0] col;                // column address
      logic [5:0] start;              // display start line
      logic seg_dir;                  // segment direction
      logic [7:0] status_byte;        // byte returned by status read
      logic [7:0] cmd;                // last command byte
      logic cmd_v;                    // sticky: a command arrived
      logic [7:0] sh;                 // serial shift register
      logic [2:0] cnt;                // serial bit counter
      logic pend_v;                   // a host access waits for commit
      logic pend_rd;                  // pending access is a read
      logic pend_a0;                  // pending access is data, not command
      logic [7:0] pend_byte;          // pending written byte
      logic [7:0] holder;             // bus holder for reads
      logic [7:0] dout;
      logic doe;
      logic seg_dot;
      logic ind_dot;
      logic awready;
      logic wready;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } lhp_state_t;

   lhp_state_t s_q;
   lhp_state_t s_d;

   // ----------------------------------------------------------------
   // pin decode, all from the second synchroniser stage
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] pins;
   logic sel;                         // both chip selects active
   logic par;                         // parallel link chosen
   logic m68;                         // enable-strobe style chosen
   logic rw;                          // direction: high reads
   logic wr80;                        // split style write done
   logic rd80;                        // split style read done
   logic e_fall;                      // enable strobe fell
   logic scl_rise;                    // serial clock rose
   logic live;                        // sy2 and prv both hold real pin levels
   logic p_wr;
   logic p_rd;
   logic s_done;                      // serial byte complete
   logic [7:0] ser_byte;
   logic oe_now;

   assign pins = {parallel_strap_i, bus_style_strap_i, chip_select_low_active_n_i,
                  chip_select_high_active_i, data_command_select_i, rd_strobe_i,
                  wr_strobe_i, data_i};
   assign sel = ~s_q.sy2[P_CSN] & s_q.sy2[P_CS2];
   assign par = s_q.sy2[P_PS];
   assign m68 = s_q.sy2[P_STY];
   assign rw = s_q.sy2[P_WR];
   assign live = s_q.fill[2];
   assign wr80 = live & par & ~m68 & sel & s_q.sy2[P_WR] & ~s_q.prv[P_WR];
   assign rd80 = live & par & ~m68 & sel & s_q.sy2[P_RD] & ~s_q.prv[P_RD];
   assign e_fall = live & par & m68 & sel & ~s_q.sy2[P_RD] & s_q.prv[P_RD];
   assign scl_rise = live & ~par & sel & s_q.sy2[P_SCL] & ~s_q.prv[P_SCL];
   assign p_wr = wr80 | (e_fall & ~rw);
   assign p_rd = rd80 | (e_fall & rw);
   assign s_done = scl_rise & (s_q.cnt == SER_LAST);
   assign ser_byte = {s_q.sh[6:0], s_q.sy2[P_SI]};
   // serial mode never drives; split style drives while read strobe low,
   // enable style while direction is high
   assign oe_now = par & sel & (m68 ? rw : ~s_q.sy2[P_RD]);

   // ----------------------------------------------------------------
   // host address side of the ram
   // ----------------------------------------------------------------
   logic addr_ok;
   logic [7:0] page_mask;
   logic [7:0] cur_byte;
   logic cmd_set;

   assign addr_ok = (s_q.page <= IND_PAGE) && (s_q.col <= COL_LAST);
   assign page_mask = (s_q.page == IND_PAGE) ? IND_MASK : FULL_MASK;
   assign cur_byte = addr_ok ? (s_q.ram[s_q.page][s_q.col] & page_mask) : '0;
   assign cmd_set = s_q.pend_v & ~s_q.pend_a0 & ~s_q.pend_rd;

   // ----------------------------------------------------------------
   // refresh read port
   // ----------------------------------------------------------------
   // separate read path on the stored bits; host writes only change a
   // byte, they never stall or reorder this port
   logic [6:0] line_sum;
   logic [6:0] line;
   logic [7:0] ref_col;
   logic ref_ok;

   assign line_sum = {1'b0, s_q.start} + {1'b0, scan_row_i};
   assign line = (line_sum >= NUM_LINES) ? 7'(line_sum - NUM_LINES) : line_sum;
   assign ref_col = s_q.seg_dir ? 8'(COL_LAST - scan_col_i) : scan_col_i;
   assign ref_ok = scan_col_i <= COL_LAST;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      // two-stage synchroniser for every pin
      s_d.sy1 = pins;
      s_d.sy2 = s_q.sy1;
      s_d.prv = s_q.sy2;
      // prv is zero right after reset, so an idle-high strobe would look
      // like a rising edge; edges count only once prv holds a real sample
      s_d.fill = {s_q.fill[1:0], 1'b1};

      // serial receiver: cleared whenever deselected
      if (!sel) begin
         s_d.sh = '0;
         s_d.cnt = '0;
      end else if (scl_rise) begin
         s_d.sh = ser_byte;
         s_d.cnt = s_q.cnt + 3'h1;
      end

      // capture one access; committed on the next cycle, long before
      // any host could start another write cycle
      s_d.pend_v = p_wr | p_rd | s_done;
      s_d.pend_rd = p_rd & ~s_done;
      s_d.pend_a0 = s_q.sy2[P_A0];
      s_d.pend_byte = s_done ? ser_byte : s_q.sy2[P_D0 +: 8];

      // commit the pending access
      if (s_q.pend_v) begin
         if (s_q.pend_a0) begin
            // one byte is eight vertically stacked dots of one column
            if (!s_q.pend_rd && addr_ok) begin
               s_d.ram[s_q.page][s_q.col] = s_q.pend_byte & page_mask;
            end
            // a read hands out the old holder and refills it
            if (s_q.pend_rd) begin
               s_d.holder = cur_byte;
            end
            // saturate: the page is never touched here
            if (s_q.col < COL_LAST) begin
               s_d.col = s_q.col + 8'h01;
            end
         end else if (!s_q.pend_rd) begin
            s_d.cmd = s_q.pend_byte;
            s_d.cmd_v = 1'b1;
         end
      end

      // pins: data read shows the holder, status read the status byte
      s_d.doe = oe_now;
      s_d.dout = s_q.sy2[P_A0] ? s_q.holder : s_q.status_byte;

      // refresh dots
      s_d.seg_dot = ref_ok ? s_q.ram[line[6:3]][ref_col][line[2:0]] : 1'b0;
      s_d.ind_dot = ref_ok ? s_q.ram[IND_PAGE][ref_col][0] : 1'b0;

      // axi write channel: address and data taken in either order
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
         s_d.aw_got = 1'b0;
         s_d.w_got = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         // software address writes override a same-cycle increment
         case (s_q.awaddr)
            REG_PAGE: begin
               if (s_q.wstrb[0]) s_d.page = s_q.wdata[3:0];
            end
            REG_COLUMN: begin
               if (s_q.wstrb[0]) s_d.col = s_q.wdata[7:0];
            end
            REG_START: begin
               if (s_q.wstrb[0]) s_d.start = s_q.wdata[5:0];
            end
            REG_SEGDIR: begin
               if (s_q.wstrb[0]) s_d.seg_dir = s_q.wdata[0];
            end
            REG_STATUS: begin
               if (s_q.wstrb[0]) s_d.status_byte = s_q.wdata[7:0];
            end
            REG_CMD: begin
               // write one clears; a command arriving now wins
               if (s_q.wstrb[1] && s_q.wdata[CMD_VALID_BIT] && !cmd_set) s_d.cmd_v = 1'b0;
            end
            REG_LINK: begin
               s_d.bresp = RESP_OKAY;
            end
            default: begin
               s_d.bresp = RESP_SLVERR;
            end
         endcase
      end
      s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
      s_d.wready = ~s_d.w_got & ~s_d.bvalid;

      // axi read channel
      if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         s_d.rdata = '0;
         case (s_axi_araddr)
            REG_PAGE: s_d.rdata[3:0] = s_q.page;
            REG_COLUMN: s_d.rdata[7:0] = s_q.col;
            REG_START: s_d.rdata[5:0] = s_q.start;
            REG_SEGDIR: s_d.rdata[0] = s_q.seg_dir;
            REG_STATUS: s_d.rdata[7:0] = s_q.status_byte;
            REG_CMD: s_d.rdata[CMD_VALID_BIT:0] = {s_q.cmd_v, s_q.cmd};
            REG_LINK: s_d.rdata[2:0] = {sel, m68, par};
            default: s_d.rresp = RESP_SLVERR;
         endcase
      end
      s_d.arready = ~s_d.rvalid;
   end

   // ----------------------------------------------------------------
   // state register, synchronous active-low reset
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // outputs straight from flip-flops
   assign data_o = s_q.dout;
   assign data_oe_o = s_q.doe;
   assign seg_dot_o = s_q.seg_dot;
   assign indicator_row_output_o = s_q.ind_dot;
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;
   assign s_axi_rvalid = s_q.rvalid;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence ser_last_edge;
      scl_rise && (s_q.cnt == SER_LAST);
   endsequence

   sequence ser_byte_out;
      s_q.pend_v && !s_q.pend_rd && (s_q.cnt == 3'h0);
   endsequence

   serial_quiet_a: assert property (!par |=> !data_oe_o)
      else $error("data bus driven in serial mode");
   desel_float_a: assert property (!sel |=> !data_oe_o)
      else $error("data bus driven while deselected");
   desel_clear_a: assert property (!sel |=> (s_q.sh == 8'h00) && (s_q.cnt == 3'h0))
      else $error("serial state kept while deselected");
   serial_byte_a: assert property (ser_last_edge |=> ser_byte_out)
      else $error("serial byte not handed over on eighth edge");
   col_sat_a: assert property (s_q.pend_v && s_q.pend_a0 && s_q.col == COL_LAST
      && !(s_q.aw_got && s_q.w_got && !s_q.bvalid) |=> s_q.col == COL_LAST)
      else $error("column ran past the last column");
   col_step_a: assert property (s_q.pend_v && s_q.pend_a0 && s_q.col < COL_LAST
      && !(s_q.aw_got && s_q.w_got && !s_q.bvalid)
      |=> s_q.col == $past(s_q.col) + 8'h01)
      else $error("column did not advance after data access");
   holder_fill_a: assert property (s_q.pend_v && s_q.pend_rd && s_q.pend_a0
      |=> s_q.holder == $past(cur_byte))
      else $error("holder not refilled by data read");
   split_drive_a: assert property (par && !m68 && sel && !s_q.sy2[P_RD]
      |=> data_oe_o ##1 (data_oe_o || !s_q.prv[P_RD] == 1'b0 || !sel || !par))
      else $error("bus not driven during read strobe");
   enable_drive_a: assert property (par && m68 && sel && rw |=> data_oe_o)
      else $error("bus not driven while direction high");
   write_commit_a: assert property (p_wr && s_q.sy2[P_A0]
      |=> s_q.pend_v && s_q.pend_a0 && !s_q.pend_rd)
      else $error("host write not queued for commit");
endmodule : lhp_host_port
`default_nettype wire

// >>> dv/lhp_host_model.sv
`default_nettype none
// ----------------------------------------------------------------
// host microprocessor on the pins, parallel or serial
// ----------------------------------------------------------------
module lhp_host_model (
   input wire logic clk_i,
   input wire logic [7:0] dev_data_i,
   input wire logic dev_oe_i,
   output logic ps_o,
   output logic sty_o,
   output logic csn_o,
   output logic cs2_o,
   output logic a0_o,
   output logic rd_o,
   output logic wr_o,
   output logic [7:0] bus_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] drv_q;  // value the host puts on the pins
   logic drv_en_q;     // host drives the pins
   // a released bus falls to the pull-down level, never the last value
   assign bus_o = dev_oe_i ? dev_data_i : (drv_en_q ? drv_q : 8'h00);
   initial begin
      ps_o = 1'b1;
      sty_o = 1'b0;
      csn_o = 1'b1;
      cs2_o = 1'b0;
      a0_o = 1'b0;
      rd_o = 1'b1;
      wr_o = 1'b1;
      drv_q = 8'h00;
      drv_en_q = 1'b0;
   end
   // straps move only while deselected; idle strobe levels follow style
   task automatic mode(input logic ps, input logic sty);
      @(posedge clk_i);
      ps_o <= ps;
      sty_o <= sty;
      rd_o <= !sty;
      wr_o <= !sty;
      repeat (6) @(posedge clk_i);
   endtask : mode
   task automatic sel(input logic on);
      @(posedge clk_i);
      csn_o <= !on;
      cs2_o <= on;
      repeat (6) @(posedge clk_i);
   endtask : sel
   // one parallel cycle; phases of 6 clocks leave room for the synchronisers
   task automatic par(input logic rd, input logic a0, input logic [7:0] d,
                      output logic [31:0] q);
      @(posedge clk_i);
      a0_o <= a0;
      drv_q <= d;
      drv_en_q <= !rd;
      if (sty_o) wr_o <= rd;
      else if (rd) rd_o <= 1'b0;
      else wr_o <= 1'b0;
      repeat (6) @(posedge clk_i);
      if (sty_o) rd_o <= 1'b1;
      repeat (6) @(posedge clk_i);
      q = {24'h000000, bus_o};
      // enable style: enable falls first, direction later, so a read never looks like a write
      if (sty_o) rd_o <= 1'b0;
      else begin
         rd_o <= 1'b1;
         wr_o <= 1'b1;
      end
      repeat (6) @(posedge clk_i);
      if (sty_o) wr_o <= 1'b0;
      drv_en_q <= 1'b0;
      repeat (6) @(posedge clk_i);
   endtask : par
   // n serial bits, msb first, 64 ns clock that rests low between frames
   task automatic ser(input logic a0, input logic [7:0] d, input int n);
      @(posedge clk_i);
      a0_o <= a0;
      drv_en_q <= 1'b1;
      for (int i = 7; i > 7 - n; i--) begin
         drv_q <= {d[i], 7'h00};
         repeat (4) @(posedge clk_i);
         drv_q[6] <= 1'b1;
         repeat (4) @(posedge clk_i);
      end
      drv_q[6] <= 1'b0;
      repeat (4) @(posedge clk_i);
      drv_en_q <= 1'b0;
   endtask : ser
endmodule : lhp_host_model
`default_nettype wire

// >>> dv/lhp_host_port_test.sv
`default_nettype none
// ----------------------------------------------------------------
// self-checking bench of the host port
// ----------------------------------------------------------------
module lhp_host_port_test;
   timeunit 1ns;
   timeprecision 1ps;
   import lhp_pkg::*;
   logic clk_i, resetn_i, parallel_strap_i, bus_style_strap_i, chip_select_low_active_n_i;
   logic chip_select_high_active_i, data_command_select_i, rd_strobe_i, wr_strobe_i;
   logic [7:0] data_i, data_o, scan_col_i, s_axi_awaddr, s_axi_araddr;
   logic data_oe_o, seg_dot_o, indicator_row_output_o;
   logic [5:0] scan_row_i;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd, q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rr;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   int n_fail = 0;
   int tests_run = 0;
   lhp_host_port lhp_host_port_i (.clk_i, .resetn_i, .parallel_strap_i, .bus_style_strap_i,
      .chip_select_low_active_n_i, .chip_select_high_active_i, .data_command_select_i,
      .rd_strobe_i, .wr_strobe_i, .data_i, .data_o, .data_oe_o, .scan_row_i, .scan_col_i,
      .seg_dot_o, .indicator_row_output_o, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   lhp_host_model lhp_host_model_i (.clk_i, .dev_data_i(data_o), .dev_oe_i(data_oe_o),
      .ps_o(parallel_strap_i), .sty_o(bus_style_strap_i), .csn_o(chip_select_low_active_n_i),
      .cs2_o(chip_select_high_active_i), .a0_o(data_command_select_i), .rd_o(rd_strobe_i),
      .wr_o(wr_strobe_i), .bus_o(data_i));
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // write: address and data offered together, each released once taken
   task automatic axi_w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk_i);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n <= 60; n++) begin
         @(posedge clk_i);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
         if (n == 60) begin
            chk(32'h0, 32'h1);
            end_sim;
         end
      end
      s_axi_bready <= 1'b0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask : axi_w
   // write with a partial strobe; full strobes return once it is answered
   task automatic axi_ws(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      s_axi_wstrb <= s;
      axi_w(a, d, RESP_OKAY);
      s_axi_wstrb <= 4'hf;
   endtask : axi_ws
   // reset low for 16 edges, level taken from the count, then pins settle
   task automatic do_reset;
      for (int i = 0; i <= 16; i++) begin
         resetn_i <= (i == 16);
         @(posedge clk_i);
      end
      repeat (3) @(posedge clk_i);
   endtask : do_reset
   task automatic axi_r(input logic [7:0] a);
      @(posedge clk_i);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n <= 60; n++) begin
         @(posedge clk_i);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
         if (n == 60) begin
            chk(32'h0, 32'h1);
            end_sim;
         end
      end
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axi_r
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      axi_r(a);
      chk(rd, e);
   endtask : rchk
   // refresh probe: outputs settle one cycle after the scan inputs
   task automatic scan(input logic [5:0] r, input logic [7:0] c, input logic d, input logic i);
      @(posedge clk_i);
      scan_row_i <= r;
      scan_col_i <= c;
      repeat (3) @(posedge clk_i);
      chk(32'(seg_dot_o), 32'(d));
      chk(32'(indicator_row_output_o), 32'(i));
   endtask : scan
   task automatic t_regs;
      axi_r(8'h40);
      chk(32'(rr), 32'(RESP_SLVERR));
      chk(rd, 32'h0);
      axi_w(8'h40, 32'h1, RESP_SLVERR);
      rchk(REG_COLUMN, 32'h0);
      rchk(REG_START, 32'h0);
      rchk(REG_SEGDIR, 32'h0);
      rchk(REG_CMD, 32'h0);
      rchk(REG_LINK, 32'h1);
      axi_w(REG_PAGE, 32'h1f, RESP_OKAY);
      rchk(REG_PAGE, 32'hf);
      axi_ws(REG_PAGE, 32'h3, 4'he);
      rchk(REG_PAGE, 32'hf);
   endtask : t_regs
   // split strobes: stream past the last column, pipelined read back
   task automatic t_split;
      axi_w(REG_PAGE, 32'h0, RESP_OKAY);
      axi_w(REG_COLUMN, 32'h82, RESP_OKAY);
      lhp_host_model_i.sel(1'b1);
      rchk(REG_LINK, 32'h5);
      lhp_host_model_i.par(1'b0, 1'b1, 8'h5a, q);
      lhp_host_model_i.par(1'b0, 1'b1, 8'hc3, q);
      lhp_host_model_i.par(1'b0, 1'b1, 8'h11, q);
      rchk(REG_COLUMN, 32'h83);
      rchk(REG_PAGE, 32'h0);
      axi_w(REG_COLUMN, 32'h82, RESP_OKAY);
      lhp_host_model_i.par(1'b1, 1'b1, 8'h00, q);
      lhp_host_model_i.par(1'b1, 1'b1, 8'h00, q);
      chk(q, 32'h5a);
      lhp_host_model_i.par(1'b1, 1'b1, 8'h00, q);
      chk(q, 32'h11);
      chk(32'(data_oe_o), 32'h0);
      lhp_host_model_i.par(1'b0, 1'b0, 8'h81, q);
      rchk(REG_CMD, 32'h181);
      axi_ws(REG_CMD, 32'h100, 4'h1);
      rchk(REG_CMD, 32'h181);
      axi_w(REG_STATUS, 32'h5c, RESP_OKAY);
      lhp_host_model_i.par(1'b1, 1'b0, 8'h00, q);
      chk(q, 32'h5c);
      lhp_host_model_i.sel(1'b0);
      lhp_host_model_i.par(1'b0, 1'b0, 8'h33, q);
      rchk(REG_CMD, 32'h181);
      lhp_host_model_i.par(1'b1, 1'b0, 8'h00, q);
      chk(q, 32'h0);
   endtask : t_split
   // enable strobe: command, status, indicator page
   task automatic t_enable;
      lhp_host_model_i.mode(1'b1, 1'b1);
      lhp_host_model_i.sel(1'b1);
      axi_w(REG_CMD, 32'h100, RESP_OKAY);
      lhp_host_model_i.par(1'b0, 1'b0, 8'haf, q);
      rchk(REG_CMD, 32'h1af);
      lhp_host_model_i.par(1'b1, 1'b0, 8'h00, q);
      chk(q, 32'h5c);
      chk(32'(data_oe_o), 32'h0);
      axi_w(REG_PAGE, 32'h8, RESP_OKAY);
      axi_w(REG_COLUMN, 32'h5, RESP_OKAY);
      lhp_host_model_i.par(1'b0, 1'b1, 8'hff, q);
      axi_w(REG_COLUMN, 32'h5, RESP_OKAY);
      lhp_host_model_i.par(1'b1, 1'b1, 8'h00, q);
      lhp_host_model_i.par(1'b1, 1'b1, 8'h00, q);
      chk(q, 32'h1);
      axi_w(REG_START, 32'h3, RESP_OKAY);
      scan(6'h00, 8'h05, 1'b0, 1'b1);
      scan(6'h00, 8'h06, 1'b0, 1'b0);
      lhp_host_model_i.sel(1'b0);
   endtask : t_enable
   // serial: aborted partial byte, then command and data bytes
   task automatic t_serial;
      lhp_host_model_i.mode(1'b0, 1'b0);
      lhp_host_model_i.sel(1'b1);
      rchk(REG_LINK, 32'h4);
      axi_w(REG_CMD, 32'h100, RESP_OKAY);
      lhp_host_model_i.ser(1'b0, 8'hff, 3);
      lhp_host_model_i.sel(1'b0);
      lhp_host_model_i.sel(1'b1);
      lhp_host_model_i.ser(1'b0, 8'ha5, 8);
      rchk(REG_CMD, 32'h1a5);
      axi_w(REG_PAGE, 32'h0, RESP_OKAY);
      axi_w(REG_COLUMN, 32'h0, RESP_OKAY);
      lhp_host_model_i.ser(1'b1, 8'h02, 8);
      chk(32'(data_oe_o), 32'h0);
      rchk(REG_COLUMN, 32'h1);
   endtask : t_serial
   // refresh: start line scroll and segment direction
   task automatic t_refresh;
      axi_w(REG_START, 32'h1, RESP_OKAY);
      scan(6'h00, 8'h00, 1'b1, 1'b0);
      scan(6'h01, 8'h00, 1'b0, 1'b0);
      axi_w(REG_START, 32'h0, RESP_OKAY);
      scan(6'h01, 8'h00, 1'b1, 1'b0);
      axi_w(REG_SEGDIR, 32'h1, RESP_OKAY);
      scan(6'h01, 8'h83, 1'b1, 1'b0);
      scan(6'h01, 8'h7e, 1'b0, 1'b1);
   endtask : t_refresh
   // reset in mid-run: registers, ram and both refresh dots return to zero
   task automatic t_reset;
      axi_w(REG_STATUS, 32'h77, RESP_OKAY);
      do_reset;
      rchk(REG_STATUS, 32'h0);
      rchk(REG_START, 32'h0);
      rchk(REG_SEGDIR, 32'h0);
      scan(6'h01, 8'h00, 1'b0, 1'b0);
      scan(6'h01, 8'h05, 1'b0, 1'b0);
   endtask : t_reset
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      s_axi_awaddr = 8'h00;
      s_axi_araddr = 8'h00;
      s_axi_wdata = 32'h0;
      s_axi_wstrb = 4'hf;
      scan_row_i = 6'h00;
      scan_col_i = 8'h00;
      do_reset;
      t_regs;
      t_split;
      t_enable;
      t_serial;
      t_refresh;
      t_reset;
      end_sim;
   end
endmodule : lhp_host_port_test
`default_nettype wire
